/* src/sbea_pkg.sv */
// Summary of operation
// - two half-overlapped 256-point transforms each frame
// - first window starts at frame sample zero
// - second window starts half a transform later
// - input weighted by sine window before transform
// - only half window stored, rest by symmetry
// - bins 0 and 128 purely real, bin 128 not emitted
// - twenty critical bands with fixed bin counts
// - bins 50 Hz wide, DC bin in no band
// - band first-bin index list fixed
// - band energy is scaled mean squared magnitude
// - bin energy is squared magnitude times 4/N^2
// - frame energy sums band energies per analysis
// - total energy dB of mean frame energy
// - power spectrum averages the two bin energies
// - narrowband input uses bands 1 to 16 only
// - relative energy is total minus long-term energy
// - long-term energy changes only on active frames
// - bandwidth detection only above 8 kHz input
// - four bandwidth modes narrow to full band
// - legacy mode selects transform-based detector source
// - pre-emphasis with 0.68 on previous sample
package sbea_pkg;
  localparam int FFT_LEN = 256;
  localparam int HALF_LEN = 128;
  localparam int WIN1_OFFSET = 128;
  localparam int FRAME_LEN = 384;
  localparam int N_BANDS = 20;
  localparam int N_BINS = 128;
  localparam int BIN_SHIFT = 14;
  localparam int BAND_SHIFT = 14;
  localparam int RECIP_SHIFT = 16;
  localparam int Q15_SHIFT = 15;
  localparam int LOG_FRAC = 8;
  localparam int SW = 16;
  localparam int MW = 17;
  localparam int AW = 26;
  localparam int PW = 52;
  localparam int EW = 40;
  localparam int DBW = 16;
  localparam int BHK_A = 16;
  localparam int BHK_B = 5;
  localparam int BHK_C = 4;
  localparam logic [8:0] QUARTER = 9'h080;
  localparam logic [7:0] LAST_N = 8'hff;
  localparam logic [7:0] NYQ_BIN = 8'h80;
  localparam logic [8:0] LAST_LOAD = 9'h17f;
  localparam logic [4:0] NB_FIRST = 5'h01;
  localparam logic [4:0] NB_LAST = 5'h10;
  localparam logic [4:0] BAND_END = 5'h14;
  localparam logic [15:0] DB_PER_OCT = 16'h0303;
  localparam logic [15:0] PRE_EMPH = 16'h570a;

  typedef logic [7:0] sbea_b8_t;
  typedef logic [15:0] sbea_tab_t [HALF_LEN+1];

  localparam sbea_b8_t BAND_START [N_BANDS] = '{
    8'h01, 8'h03, 8'h05, 8'h07, 8'h09, 8'h0b, 8'h0d, 8'h10, 8'h13, 8'h16,
    8'h1a, 8'h1e, 8'h23, 8'h29, 8'h2f, 8'h37, 8'h40, 8'h4b, 8'h59, 8'h6b};
  localparam sbea_b8_t BAND_BINS [N_BANDS] = '{
    8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h03, 8'h03, 8'h03, 8'h04,
    8'h04, 8'h05, 8'h06, 8'h06, 8'h08, 8'h09, 8'h0b, 8'h0e, 8'h12, 8'h15};
  localparam logic [15:0] BAND_RECIP [N_BANDS] = '{
    16'h8000, 16'h8000, 16'h8000, 16'h8000, 16'h8000, 16'h8000,
    16'h5555, 16'h5555, 16'h5555, 16'h4000, 16'h4000, 16'h3333,
    16'h2aab, 16'h2aab, 16'h2000, 16'h1c72, 16'h1746, 16'h1249,
    16'h0e39, 16'h0c31};

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_LOAD = 4'b0001,
    ST_CALC = 4'b0010,
    ST_POWER = 4'b0011,
    ST_EMIT = 4'b0100,
    ST_NEXT = 4'b0101,
    ST_LOGDB = 4'b0110,
    ST_REL = 4'b0111
  } sbea_state_t;

  typedef enum logic [1:0] {
    BW_NARROW = 2'b00,
    BW_WIDE = 2'b01,
    BW_SUPER = 2'b10,
    BW_FULL = 2'b11
  } sbea_bw_t;

  typedef enum logic [1:0] {
    RATE_8K = 2'b00,
    RATE_16K = 2'b01,
    RATE_32K = 2'b10,
    RATE_48K = 2'b11
  } sbea_rate_t;

  typedef enum logic [2:0] {
    WK_BAND0 = 3'b000,
    WK_BAND1 = 3'b001,
    WK_BIN0 = 3'b010,
    WK_BIN1 = 3'b011,
    WK_PS = 3'b100
  } sbea_kind_t;

  typedef struct packed {
    sbea_kind_t kind;
    logic [7:0] index;
    logic [EW-1:0] value;
  } sbea_word_t;

  // sin(pi*m/256) in Q15, rational approximation
  function automatic sbea_tab_t sbeaSineTab();
    sbea_tab_t t;
    longint p;
    longint num;
    longint den;
    for (int m = 0; m <= HALF_LEN; m++) begin
      p = longint'(m) * longint'(FFT_LEN - m);
      num = longint'(BHK_A) * p * (longint'(1) << Q15_SHIFT);
      den = longint'(BHK_B * FFT_LEN * FFT_LEN) - longint'(BHK_C) * p;
      t[m] = 16'(num / den);
    end
    return t;
  endfunction
endpackage

/* src/sbea_sine.sv */
`timescale 1ns/1ps
module sbea_sine
  import sbea_pkg::*;
(
  input wire logic [8:0] phase,
  output logic signed [16:0] val
);
  localparam sbea_tab_t TAB = sbeaSineTab();
  logic [7:0] idx;
  logic signed [16:0] mag;

  // half table 0..128, mirrored about 128
  always_comb begin
    idx = phase[7] ? 8'(8'h00 - phase[7:0]) : phase[7:0];
    mag = $signed({1'b0, TAB[idx]});
    val = phase[8] ? -mag : mag;
  end
endmodule

/* src/sbea_core.sv */
`timescale 1ns/1ps
module sbea_core
  import sbea_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic frameStart,
  input wire logic sampleValid,
  input wire logic signed [SW-1:0] sampleIn,
  output logic sampleReady_r,
  input wire logic narrowIn,
  input wire sbea_rate_t rateIn,
  input wire logic legacyMode,
  input wire logic signed [DBW-1:0] ltEnergyIn,
  input wire logic ltUpdate,
  input wire logic frameActive,
  output sbea_word_t outWord_r,
  output logic outValid_r,
  input wire logic outReady,
  output logic [DBW-1:0] frameDb_r,
  output logic signed [DBW-1:0] relEnergy_r,
  output logic resultsValid_r,
  output logic bwDetectEn_r,
  output sbea_bw_t bwMaxMode_r,
  output logic detSrcDct_r
);
  localparam int PRW = PW + 16;

  sbea_state_t state_r, state_nxt;
  logic signed [MW-1:0] sampMem_r [FRAME_LEN];
  logic signed [MW-1:0] sampMem_nxt [FRAME_LEN];
  logic [EW-1:0] binMem_r [N_BINS];
  logic [EW-1:0] binMem_nxt [N_BINS];
  logic [8:0] loadIdx_r, loadIdx_nxt;
  logic signed [SW-1:0] prevSamp_r, prevSamp_nxt;
  logic ana_r, ana_nxt;
  logic [7:0] kIdx_r, kIdx_nxt, nIdx_r, nIdx_nxt, phase_r, phase_nxt;
  logic signed [AW-1:0] accR_r, accR_nxt, accI_r, accI_nxt;
  logic [PW-1:0] bandSum_r, bandSum_nxt;
  logic [4:0] band_r, band_nxt, bandOut_r, bandOut_nxt;
  logic [EW-1:0] binE_r, binE_nxt, psVal_r, psVal_nxt;
  logic [EW-1:0] bandE_r, bandE_nxt;
  logic [EW-1:0] frameAcc_r [2];
  logic [EW-1:0] frameAcc_nxt [2];
  logic [2:0] pend_r, pend_nxt;
  logic narrow_r, narrow_nxt;
  logic sampleReady_nxt, resultsValid_nxt;
  logic bwDetectEn_nxt, detSrcDct_nxt;
  sbea_bw_t bwMaxMode_nxt;
  logic [DBW-1:0] frameDb_nxt;
  logic signed [DBW-1:0] relEnergy_nxt, ltEnergy_r, ltEnergy_nxt;

  logic signed [16:0] winVal, cosVal, sinVal;
  logic signed [MW-1:0] xRaw, xWin;
  logic signed [MW+16:0] prodW, prodC, prodS;
  logic [8:0] sampAddr;
  logic signed [PW-1:0] sqR, sqI;
  logic [PW-1:0] power, sumNow;
  logic [PRW-1:0] bandProd;
  logic [4:0] bIdx;
  logic [7:0] bandLast;
  logic signed [SW+1:0] preEmph;
  logic signed [31:0] preProd;
  logic [EW:0] avgE;
  logic [EW-1:0] shifted;
  logic [5:0] msb;
  logic [13:0] log2q;
  logic [29:0] dbProd;
  logic bufInValid, bufInReady_r;
  sbea_word_t bufInWord;

  ////////////////////////////////////////////////////////////////////////
  // trig and window lookups
  sbea_sine uWin (.phase({1'b0, nIdx_r}), .val(winVal));
  sbea_sine uCos (.phase(9'({phase_r, 1'b0} + QUARTER)), .val(cosVal));
  sbea_sine uSin (.phase({phase_r, 1'b0}), .val(sinVal));

  ////////////////////////////////////////////////////////////////////////
  // analysis engine
  always_comb begin
    state_nxt = state_r;
    sampMem_nxt = sampMem_r;
    binMem_nxt = binMem_r;
    loadIdx_nxt = loadIdx_r;
    prevSamp_nxt = prevSamp_r;
    ana_nxt = ana_r;
    kIdx_nxt = kIdx_r;
    nIdx_nxt = nIdx_r;
    phase_nxt = phase_r;
    accR_nxt = accR_r;
    accI_nxt = accI_r;
    bandSum_nxt = bandSum_r;
    band_nxt = band_r;
    bandOut_nxt = bandOut_r;
    binE_nxt = binE_r;
    psVal_nxt = psVal_r;
    bandE_nxt = bandE_r;
    frameAcc_nxt = frameAcc_r;
    pend_nxt = pend_r;
    narrow_nxt = narrow_r;
    sampleReady_nxt = sampleReady_r;
    resultsValid_nxt = resultsValid_r;
    bwDetectEn_nxt = bwDetectEn_r;
    bwMaxMode_nxt = bwMaxMode_r;
    detSrcDct_nxt = detSrcDct_r;
    frameDb_nxt = frameDb_r;
    relEnergy_nxt = relEnergy_r;
    ltEnergy_nxt = ltEnergy_r;
    if (ltUpdate && frameActive) begin
      ltEnergy_nxt = ltEnergyIn;
    end
    preProd = 32'(prevSamp_r) * $signed({16'h0000, PRE_EMPH});
    preEmph = (SW+2)'(sampleIn) - (SW+2)'(preProd >>> Q15_SHIFT);
    sampAddr = 9'({1'b0, nIdx_r} +
                  (ana_r ? 9'(WIN1_OFFSET) : 9'h000));
    xRaw = sampMem_r[sampAddr];
    prodW = (MW+17)'(xRaw) * (MW+17)'(winVal);
    xWin = MW'(prodW >>> Q15_SHIFT);
    prodC = (MW+17)'(xWin) * (MW+17)'(cosVal);
    prodS = (MW+17)'(xWin) * (MW+17)'(sinVal);
    sqR = PW'(accR_r) * PW'(accR_r);
    sqI = PW'(accI_r) * PW'(accI_r);
    if (kIdx_r == 8'h00 || kIdx_r == NYQ_BIN) begin
      sqI = '0;
    end
    power = PW'(sqR) + PW'(sqI);
    bIdx = (band_r < BAND_END) ? band_r : 5'h00;
    bandLast = 8'(BAND_START[bIdx] + BAND_BINS[bIdx] - 8'h01);
    sumNow = bandSum_r + power;
    bandProd = PRW'(sumNow >> BAND_SHIFT) * PRW'(BAND_RECIP[bIdx]);
    avgE = ((EW+1)'(frameAcc_r[0]) + (EW+1)'(frameAcc_r[1])) >> 1;
    msb = 6'h00;
    for (int i = 0; i < EW; i++) begin
      if (avgE[i]) begin
        msb = 6'(i);
      end
    end
    shifted = EW'(avgE << (6'(EW - 1) - msb));
    log2q = {msb, shifted[EW-2 -: LOG_FRAC]};
    dbProd = 30'(log2q) * 30'(DB_PER_OCT);
    case (state_r)
      ST_IDLE: begin
        if (frameStart) begin
          resultsValid_nxt = 1'b0;
          sampleReady_nxt = 1'b1;
          loadIdx_nxt = 9'h000;
          narrow_nxt = narrowIn;
          bwDetectEn_nxt = (rateIn != RATE_8K);
          bwMaxMode_nxt = sbea_bw_t'(rateIn);
          detSrcDct_nxt = legacyMode;
          state_nxt = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (sampleValid && sampleReady_r) begin
          sampMem_nxt[loadIdx_r] = MW'(preEmph);
          prevSamp_nxt = sampleIn;
          loadIdx_nxt = 9'(loadIdx_r + 9'h001);
          if (loadIdx_r == LAST_LOAD) begin
            sampleReady_nxt = 1'b0;
            ana_nxt = 1'b0;
            kIdx_nxt = 8'h00;
            nIdx_nxt = 8'h00;
            phase_nxt = 8'h00;
            accR_nxt = '0;
            accI_nxt = '0;
            band_nxt = 5'h00;
            bandSum_nxt = '0;
            frameAcc_nxt[0] = '0;
            frameAcc_nxt[1] = '0;
            state_nxt = ST_CALC;
          end
        end
      end
      ST_CALC: begin
        accR_nxt = AW'(accR_r + AW'(prodC >>> Q15_SHIFT));
        accI_nxt = AW'(accI_r - AW'(prodS >>> Q15_SHIFT));
        nIdx_nxt = 8'(nIdx_r + 8'h01);
        phase_nxt = 8'(phase_r + kIdx_r);
        if (nIdx_r == LAST_N) begin
          state_nxt = ST_POWER;
        end
      end
      ST_POWER: begin
        state_nxt = ST_NEXT;
        if (kIdx_r != NYQ_BIN) begin
          state_nxt = ST_EMIT;
          binE_nxt = EW'(power >> BIN_SHIFT);
          pend_nxt = {1'b0, ana_r, 1'b1};
          if (!ana_r) begin
            binMem_nxt[kIdx_r[6:0]] = EW'(power >> BIN_SHIFT);
          end
          psVal_nxt = EW'(((EW+1)'(binMem_r[kIdx_r[6:0]]) +
                           (EW+1)'(power >> BIN_SHIFT)) >> 1);
          if (kIdx_r != 8'h00 && band_r < BAND_END) begin
            bandSum_nxt = sumNow;
            if (kIdx_r == bandLast) begin
              bandE_nxt = EW'(bandProd >> RECIP_SHIFT);
              bandOut_nxt = band_r;
              bandSum_nxt = '0;
              band_nxt = 5'(band_r + 5'h01);
              if (!narrow_r ||
                  (band_r >= NB_FIRST && band_r <= NB_LAST)) begin
                pend_nxt[2] = 1'b1;
                frameAcc_nxt[ana_r] = EW'(frameAcc_r[ana_r] +
                                          EW'(bandProd >> RECIP_SHIFT));
              end
            end
          end
        end
      end
      ST_EMIT: begin
        if (pend_r == 3'b000) begin
          state_nxt = ST_NEXT;
        end else if (bufInReady_r) begin
          if (pend_r[0]) begin
            pend_nxt[0] = 1'b0;
          end else if (pend_r[1]) begin
            pend_nxt[1] = 1'b0;
          end else begin
            pend_nxt[2] = 1'b0;
          end
        end
      end
      ST_NEXT: begin
        accR_nxt = '0;
        accI_nxt = '0;
        nIdx_nxt = 8'h00;
        phase_nxt = 8'h00;
        kIdx_nxt = 8'(kIdx_r + 8'h01);
        state_nxt = ST_CALC;
        if (kIdx_r == NYQ_BIN) begin
          kIdx_nxt = 8'h00;
          band_nxt = 5'h00;
          ana_nxt = 1'b1;
          if (ana_r) begin
            state_nxt = ST_LOGDB;
          end
        end
      end
      ST_LOGDB: begin
        frameDb_nxt = (avgE == '0) ? '0 : DBW'(dbProd >> LOG_FRAC);
        state_nxt = ST_REL;
      end
      ST_REL: begin
        relEnergy_nxt = DBW'(frameDb_r - ltEnergy_r);
        resultsValid_nxt = 1'b1;
        state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ST_IDLE;
      for (int i = 0; i < FRAME_LEN; i++) begin
        sampMem_r[i] <= '0;
      end
      for (int i = 0; i < N_BINS; i++) begin
        binMem_r[i] <= '0;
      end
      loadIdx_r <= 9'h000;
      prevSamp_r <= '0;
      ana_r <= 1'b0;
      kIdx_r <= 8'h00;
      nIdx_r <= 8'h00;
      phase_r <= 8'h00;
      accR_r <= '0;
      accI_r <= '0;
      bandSum_r <= '0;
      band_r <= 5'h00;
      bandOut_r <= 5'h00;
      binE_r <= '0;
      psVal_r <= '0;
      bandE_r <= '0;
      frameAcc_r[0] <= '0;
      frameAcc_r[1] <= '0;
      pend_r <= 3'b000;
      narrow_r <= 1'b0;
      sampleReady_r <= 1'b0;
      resultsValid_r <= 1'b0;
      bwDetectEn_r <= 1'b0;
      bwMaxMode_r <= BW_NARROW;
      detSrcDct_r <= 1'b0;
      frameDb_r <= '0;
      relEnergy_r <= '0;
      ltEnergy_r <= '0;
    end else begin
      state_r <= state_nxt;
      sampMem_r <= sampMem_nxt;
      binMem_r <= binMem_nxt;
      loadIdx_r <= loadIdx_nxt;
      prevSamp_r <= prevSamp_nxt;
      ana_r <= ana_nxt;
      kIdx_r <= kIdx_nxt;
      nIdx_r <= nIdx_nxt;
      phase_r <= phase_nxt;
      accR_r <= accR_nxt;
      accI_r <= accI_nxt;
      bandSum_r <= bandSum_nxt;
      band_r <= band_nxt;
      bandOut_r <= bandOut_nxt;
      binE_r <= binE_nxt;
      psVal_r <= psVal_nxt;
      bandE_r <= bandE_nxt;
      frameAcc_r <= frameAcc_nxt;
      pend_r <= pend_nxt;
      narrow_r <= narrow_nxt;
      sampleReady_r <= sampleReady_nxt;
      resultsValid_r <= resultsValid_nxt;
      bwDetectEn_r <= bwDetectEn_nxt;
      bwMaxMode_r <= bwMaxMode_nxt;
      detSrcDct_r <= detSrcDct_nxt;
      frameDb_r <= frameDb_nxt;
      relEnergy_r <= relEnergy_nxt;
      ltEnergy_r <= ltEnergy_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // two-entry output buffer
  sbea_word_t skidWord_r, skidWord_nxt, outWord_nxt;
  logic skidValid_r, skidValid_nxt, outValid_nxt, bufInReady_nxt;

  always_comb begin
    bufInValid = (state_r == ST_EMIT) && (pend_r != 3'b000);
    bufInWord = '{kind: WK_BIN0, index: 8'h00, value: '0};
    if (pend_r[0]) begin
      bufInWord = '{kind: ana_r ? WK_BIN1 : WK_BIN0, index: kIdx_r,
                    value: binE_r};
    end else if (pend_r[1]) begin
      bufInWord = '{kind: WK_PS, index: kIdx_r, value: psVal_r};
    end else if (pend_r[2]) begin
      bufInWord = '{kind: ana_r ? WK_BAND1 : WK_BAND0,
                    index: {3'b000, bandOut_r}, value: bandE_r};
    end
    outWord_nxt = outWord_r;
    outValid_nxt = outValid_r;
    skidWord_nxt = skidWord_r;
    skidValid_nxt = skidValid_r;
    if (!outValid_r || outReady) begin
      if (skidValid_r) begin
        outWord_nxt = skidWord_r;
        outValid_nxt = 1'b1;
        skidValid_nxt = 1'b0;
      end else begin
        outWord_nxt = bufInWord;
        outValid_nxt = bufInValid && bufInReady_r;
      end
    end else if (bufInValid && bufInReady_r) begin
      skidWord_nxt = bufInWord;
      skidValid_nxt = 1'b1;
    end
    bufInReady_nxt = !skidValid_nxt;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      outWord_r <= '{kind: WK_BIN0, index: 8'h00, value: '0};
      outValid_r <= 1'b0;
      skidWord_r <= '{kind: WK_BIN0, index: 8'h00, value: '0};
      skidValid_r <= 1'b0;
      bufInReady_r <= 1'b1;
    end else begin
      outWord_r <= outWord_nxt;
      outValid_r <= outValid_nxt;
      skidWord_r <= skidWord_nxt;
      skidValid_r <= skidValid_nxt;
      bufInReady_r <= bufInReady_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  sequence seqFinish;
    state_r == ST_LOGDB ##1 state_r == ST_REL ##1 resultsValid_r;
  endsequence

  chk_finish_order: assert property (state_r == ST_LOGDB |-> seqFinish)
    else $error("results not flagged two cycles after log step");
  chk_ready_load: assert property (sampleReady_r |-> state_r == ST_LOAD)
    else $error("sample ready outside load");
  chk_lt_hold: assert property (
      !(ltUpdate && frameActive) |=> $stable(ltEnergy_r))
    else $error("long-term energy changed without active update");
  chk_rel_value: assert property ($rose(resultsValid_r) |->
      relEnergy_r == DBW'(frameDb_r - $past(ltEnergy_r)))
    else $error("relative energy mismatch");
  chk_calc_span: assert property (state_r == ST_CALC && nIdx_r == LAST_N
      |=> state_r == ST_POWER ##1 state_r != ST_CALC)
    else $error("transform length not 256");
  chk_bw_mode: assert property (state_r == ST_IDLE && frameStart |=>
      bwDetectEn_r == (bwMaxMode_r != BW_NARROW))
    else $error("detect enable disagrees with mode");
  chk_dct_source: assert property (state_r == ST_IDLE && frameStart |=>
      detSrcDct_r == $past(legacyMode))
    else $error("detector source not latched");
  chk_band_range: assert property (bufInValid && bufInReady_r &&
      !pend_r[0] && !pend_r[1] && narrow_r |->
      bandOut_r >= NB_FIRST && bandOut_r <= NB_LAST)
    else $error("narrowband emitted an excluded band");
  chk_bin_index: assert property (bufInValid && pend_r[0] |->
      kIdx_r < NYQ_BIN)
    else $error("bin word beyond bin 127");
  chk_ps_pair: assert property (bufInValid && bufInReady_r && pend_r[0]
      && ana_r |=> pend_r[1] && !pend_r[0])
    else $error("power spectrum word not following bin word");
endmodule

/* sim/sbea_partner.sv */
`timescale 1ns/1ps
module sbea_partner
  import sbea_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic go,
  input wire logic stall,
  input wire logic signed [SW-1:0] amp,
  input wire logic sampleReady_r,
  output logic frameStart = 1'b0,
  output logic sampleValid = 1'b0,
  output logic signed [SW-1:0] sampleIn = '0,
  output logic outReady = 1'b1
);
  int n = 0;
  int cyc = 0;
  logic act = 0;
  logic goSeen = 0;

  ////////////////////////////////////////////////////////////////////////////
  // source: counts samples taken in the frame
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      act <= 0;
      n <= 0;
      goSeen <= 0;
    end else begin
      goSeen <= go;
      if (frameStart) begin
        act <= 1;
        n <= 0;
      end else if (sampleValid && sampleReady_r) n <= n + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // drive off the falling edge; idle data keeps toggling
  always @(negedge clock) begin
    frameStart <= goSeen;
    sampleValid <= act && n < FRAME_LEN;
    if (act && n < FRAME_LEN) sampleIn <= (n & 8) ? amp : -amp;
    else sampleIn <= ~sampleIn;
    outReady <= !(stall && cyc % 3 == 0);
    cyc <= cyc + 1;
  end
endmodule

/* sim/spectral_band_energy_analyzer_tb.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
  miscompares++; $display("BAD %s exp %0h got %0h", nm, e, g); end end

module spectral_band_energy_analyzer_tb;
  import sbea_pkg::*;
  logic clock = 0;
  logic arst_n = 0;
  logic go = 0, stall = 0, narrowIn = 0, legacyMode = 0;
  logic ltUpdate = 0, frameActive = 0;
  sbea_rate_t rateIn = RATE_8K;
  logic signed [DBW-1:0] ltEnergyIn = '0;
  logic signed [SW-1:0] amp = 16'sh1000;
  logic frameStart, sampleValid, sampleReady_r, outValid_r, outReady;
  logic signed [SW-1:0] sampleIn;
  sbea_word_t outWord_r;
  logic [DBW-1:0] frameDb_r;
  logic signed [DBW-1:0] relEnergy_r;
  logic resultsValid_r, bwDetectEn_r, detSrcDct_r;
  sbea_bw_t bwMaxMode_r;
  int miscompares = 0, num_checks = 0;
  sbea_word_t wq[$];
  localparam int FIRST [21] = '{1, 3, 5, 7, 9, 11, 13, 16, 19, 22, 26, 30,
    35, 41, 47, 55, 64, 75, 89, 107, 128};

  always #12.5 clock = ~clock;

  sbea_core dut (.clock(clock), .arst_n(arst_n), .frameStart(frameStart),
    .sampleValid(sampleValid), .sampleIn(sampleIn),
    .sampleReady_r(sampleReady_r), .narrowIn(narrowIn), .rateIn(rateIn),
    .legacyMode(legacyMode), .ltEnergyIn(ltEnergyIn), .ltUpdate(ltUpdate),
    .frameActive(frameActive), .outWord_r(outWord_r),
    .outValid_r(outValid_r), .outReady(outReady), .frameDb_r(frameDb_r),
    .relEnergy_r(relEnergy_r), .resultsValid_r(resultsValid_r),
    .bwDetectEn_r(bwDetectEn_r), .bwMaxMode_r(bwMaxMode_r),
    .detSrcDct_r(detSrcDct_r));

  sbea_partner peer (.clock(clock), .arst_n(arst_n), .go(go), .stall(stall),
    .amp(amp), .sampleReady_r(sampleReady_r), .frameStart(frameStart),
    .sampleValid(sampleValid), .sampleIn(sampleIn), .outReady(outReady));

  always @(posedge clock)
    if (arst_n && outValid_r && outReady) wq.push_back(outWord_r);

  ////////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic start_frame();
    go = 1;
    cyc(1);
    go = 0;
    cyc(4);
  endtask

  task automatic pulse_reset();
    arst_n = 0;
    cyc(2);
    arst_n = 1;
  endtask

  task automatic wait_words(input int nw);
    int k = 0;
    while (wq.size() < nw && k < 90000) begin
      @(negedge clock);
      k++;
    end
  endtask

  task automatic chk_order(input bit nb, input int nw);
    sbea_word_t e[$];
    int bad = nw;
    for (int a = 0; a < 2; a++)
      for (int k = 0; k < N_BINS; k++) begin
        e.push_back(sbea_word_t'{a ? WK_BIN1 : WK_BIN0, 8'(k), '0});
        if (a == 1) e.push_back(sbea_word_t'{WK_PS, 8'(k), '0});
        for (int b = 0; b < N_BANDS; b++)
          if (FIRST[b+1] - 1 == k && (!nb || (b > 0 && b < 17)))
            e.push_back(sbea_word_t'{a ? WK_BAND1 : WK_BAND0, 8'(b), '0});
      end
    for (int i = 0; i < nw && bad == nw; i++)
      if (wq[i].kind !== e[i].kind || wq[i].index !== e[i].index) bad = i;
    `CHK("order", nw, bad)
  endtask

  task automatic chk_energy();
    longint be [2][128];
    longint f [2];
    longint s, v, m, d;
    real db;
    f = '{0, 0};
    foreach (wq[i]) begin
      v = longint'(wq[i].value);
      case (wq[i].kind)
        WK_BIN0, WK_BIN1: be[wq[i].kind[0]][wq[i].index] = v;
        WK_PS: begin
          s = be[0][wq[i].index] + be[1][wq[i].index] - 2 * v;
          `CHK("ps", 1'b1, s >= -1 && s <= 2)
        end
        default: begin
          m = FIRST[wq[i].index + 1] - FIRST[wq[i].index];
          s = 0;
          for (int k = 0; k < m; k++)
            s += be[wq[i].kind[0]][FIRST[wq[i].index] + k];
          d = v * m - s;
          d = (d < 0 ? -d : d) - s / 4096 - 2 * m;
          `CHK("band", 1'b1, d <= 0)
          f[wq[i].kind[0]] += v;
        end
      endcase
    end
    db = 10.0 * $log10(0.5 * (f[0] + f[1])) * 256.0 - frameDb_r;
    `CHK("db", 1'b1, db < 128.0 && db > -128.0)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    pulse_reset();
    cyc(1);
    `CHK("ready", 1'b0, sampleReady_r)
    `CHK("ovalid", 1'b0, outValid_r)
    `CHK("rvalid", 1'b0, resultsValid_r)
  endtask

  task automatic t_config();
    for (int r = 0; r < 4; r++) begin
      rateIn = sbea_rate_t'(r);
      legacyMode = r[0];
      start_frame();
      `CHK("bwen", r != 0, bwDetectEn_r)
      `CHK("bwmode", sbea_bw_t'(r), bwMaxMode_r)
      `CHK("detsrc", r[0], detSrcDct_r)
      `CHK("rdy", 1'b1, sampleReady_r)
      pulse_reset();
    end
  endtask

  task automatic t_full();
    ltEnergyIn = 16'sh0200;
    frameActive = 1;
    ltUpdate = 1;
    cyc(1);
    ltEnergyIn = 16'sh7000;
    frameActive = 0;
    cyc(1);
    ltUpdate = 0;
    rateIn = RATE_16K;
    stall = 1;
    wq.delete();
    start_frame();
    `CHK("rv0", 1'b0, resultsValid_r)
    wait_words(424);
    cyc(300);
    `CHK("rv1", 1'b1, resultsValid_r)
    `CHK("nwords", 424, wq.size())
    chk_order(0, 424);
    chk_energy();
    `CHK("rel", 16'(frameDb_r - 16'h0200), relEnergy_r)
    stall = 0;
  endtask

  task automatic t_narrow();
    narrowIn = 1;
    wq.delete();
    start_frame();
    `CHK("rvdrop", 1'b0, resultsValid_r)
    wait_words(145);
    chk_order(1, 145);
    pulse_reset();
  endtask

  task automatic test_done();
    if (miscompares == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    t_reset();
    t_config();
    t_full();
    t_narrow();
    test_done();
  end

  initial begin
    repeat (150000) @(posedge clock);
    miscompares++;
    test_done();
  end
endmodule
